// ===== design/csf_fault_report.sv
// per-channel state machines, fault bookkeeping and status reporting
`timescale 1ns/10ps
`include "csf_map.svh"

// Operation
// - each channel holds one of six states; only play switches, diagnostic_state stops the oscillator.
// - channel states are reported in two registers, channels 1-2 and channels 3-4.
// - a protected channel leaves play with outputs off; self-recovering shutdown returns to play.
// - power or clock faults for all give auto recovery; channel or global over-temp only with the auto recovery bit set.
// - over-current, load, dc or channel over-temp latch one channel; global over-temp latches all.
// - latched channels stay until the host sets fault clear, which clears faults and goes to hi-z.
// - status outputs always show live state, power, temperature, clock, warning and foldback.
// - masks choose which events drive the warning and fault signals.
// - memory registers latch events until read, and a read changes nothing else.
// - after logic supply reset all settings default and the reset flag is set in power memory.
// - power faults report code 100 and appear in power status and power memory.
// - after logic supply reset channels report code 001 with no live status for it.
// - over-current, dc, load and non-recovering over-temp report code 101.
// - with the auto recovery bit set over-temp gives self-recovering shutdown instead.
// - over-current events appear in no status, only in the over-current and dc memory.
module csf_fault_report
	import csf_pkg::*;
(
	// clock and reset (reset is the logic supply power-on reset)
	input  wire logic                 i_sys_clk,
	input  wire logic                 i_rst,
	// fault sources
	input  csf_pkg::csf_chan_ev_t     i_chan_ev,
	input  csf_pkg::csf_dev_ev_t      i_dev_ev,
	// host controls
	input  csf_pkg::csf_ctrl_t        i_ctrl,
	input  wire logic [8:0]           i_warn_mask,
	input  wire logic [8:0]           i_fault_mask,
	// memory register read strobes: pwr, oc_dc, temp_clk, load, warn
	input  wire logic [4:0]           i_mem_rd,
	// channel outputs
	output logic      [3:0]           o_switching,
	output logic      [3:0]           o_osc_run,
	// status
	output logic      [7:0]           o_state_12,
	output logic      [7:0]           o_state_34,
	output logic      [7:0]           o_pwr_status,
	output logic      [7:0]           o_temp_clk_status,
	output logic      [7:0]           o_warn_status,
	output csf_pkg::csf_mem_t         o_mem,
	// alert signals, active low like the open drain pins they feed
	output logic                      o_warn_n,
	output logic                      o_fault_n
);
	csf_state_t     st [4];
	csf_state_t     next_st [4];
	logic           pwr_any;
	logic           clear_pulse;
	logic           clear_seen;
	logic [3:0]     latch_cause;
	logic [3:0]     auto_cause;
	logic [7:0]     next_pwr_status;
	logic [7:0]     next_tc_status;
	logic [7:0]     next_warn_status;
	logic [8:0]     ev_vec;
	csf_mem_t       mem_set;
	csf_mem_t       mem_rst_val;

	function automatic logic [2:0] state_code(input csf_state_t s);
		case (s)
			CSF_DIAGNOSTIC_STATE: state_code = `CSF_CODE_DIAGNOSTIC_STATE;
			CSF_HIZ:  state_code = `CSF_CODE_HIZ;
			CSF_MUTE: state_code = `CSF_CODE_MUTE;
			CSF_PLAY: state_code = `CSF_CODE_PLAY;
			CSF_SRSD: state_code = `CSF_CODE_SRSD;
			CSF_LPSD: state_code = `CSF_CODE_LPSD;
			default:  state_code = `CSF_CODE_HIZ;
		endcase
	endfunction : state_code

	assign pwr_any = i_dev_ev.vbat_ov | i_dev_ev.vbat_uv | i_dev_ev.power_stage_supply_ov
		| i_dev_ev.power_stage_supply_uv | i_dev_ev.gate_drive_supply;

	// fault clear is edge-detected so a held bit clears only once
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			clear_seen <= 1'b0;
		end else begin
			clear_seen <= i_ctrl.fault_clear;
		end
	end
	assign clear_pulse = i_ctrl.fault_clear & ~clear_seen;

	genvar g;
	generate
		for (g = 0; g < `CSF_NCH; g++) begin : g_ch
			// over-temp goes latched unless auto recovery is enabled
			assign latch_cause[g] = i_chan_ev.over_current_shutdown[g] | i_chan_ev.dc_fault[g]
				| i_chan_ev.load_fault[g]
				| (~i_ctrl.over_temp_shutdown_auto_rec & (i_chan_ev.ch_over_temp_shutdown[g] | i_dev_ev.over_temp_shutdown));
			assign auto_cause[g] = pwr_any | i_dev_ev.clk_invalid
				| (i_ctrl.over_temp_shutdown_auto_rec & (i_chan_ev.ch_over_temp_shutdown[g] | i_dev_ev.over_temp_shutdown));

			always_comb begin
				next_st[g] = st[g];
				case (st[g])
					CSF_LPSD: begin
						if (clear_pulse) begin
							next_st[g] = CSF_HIZ;
						end
					end
					CSF_SRSD: begin
						if (latch_cause[g]) begin
							next_st[g] = CSF_LPSD;
						end else if (!auto_cause[g]) begin
							next_st[g] = CSF_PLAY;
						end
					end
					CSF_PLAY: begin
						if (latch_cause[g]) begin
							next_st[g] = CSF_LPSD;
						end else if (auto_cause[g]) begin
							next_st[g] = CSF_SRSD;
						end else if (i_ctrl.run_diagnostic_state) begin
							next_st[g] = CSF_DIAGNOSTIC_STATE;
						end else if (i_ctrl.go_hiz) begin
							next_st[g] = CSF_HIZ;
						end else if (i_ctrl.go_mute) begin
							next_st[g] = CSF_MUTE;
						end
					end
					CSF_DIAGNOSTIC_STATE, CSF_HIZ, CSF_MUTE: begin
						if (i_ctrl.run_diagnostic_state) begin
							next_st[g] = CSF_DIAGNOSTIC_STATE;
						end else if (i_ctrl.go_hiz) begin
							next_st[g] = CSF_HIZ;
						end else if (i_ctrl.go_mute) begin
							next_st[g] = CSF_MUTE;
						end else if (i_ctrl.go_play) begin
							next_st[g] = CSF_PLAY;
						end
					end
					default: next_st[g] = CSF_HIZ;
				endcase
			end

			always_ff @(posedge i_sys_clk) begin
				if (i_rst) begin
					st[g] <= CSF_HIZ;
				end else begin
					st[g] <= next_st[g];
				end
			end

			// outputs switch only in play; only diagnostic_state stops the oscillator
			always_ff @(posedge i_sys_clk) begin
				if (i_rst) begin
					o_switching[g] <= 1'b0;
					o_osc_run[g]   <= 1'b1;
				end else begin
					o_switching[g] <= (next_st[g] == CSF_PLAY);
					o_osc_run[g]   <= (next_st[g] != CSF_DIAGNOSTIC_STATE);
				end
			end
		end
	endgenerate

	// channel state report
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_state_12 <= {1'b0, `CSF_CODE_HIZ, 1'b0, `CSF_CODE_HIZ};
			o_state_34 <= {1'b0, `CSF_CODE_HIZ, 1'b0, `CSF_CODE_HIZ};
		end else begin
			o_state_12 <= {1'b0, state_code(st[1]), 1'b0, state_code(st[0])};
			o_state_34 <= {1'b0, state_code(st[3]), 1'b0, state_code(st[2])};
		end
	end

	// live status: the reset flag and over-current events have no status bit
	always_comb begin
		next_pwr_status = `CSF_BYTE_ZERO;
		next_pwr_status[`CSF_PWR_VBAT_OV] = i_dev_ev.vbat_ov;
		next_pwr_status[`CSF_PWR_VBAT_UV] = i_dev_ev.vbat_uv;
		next_pwr_status[`CSF_PWR_POWER_STAGE_SUPPLY_OV] = i_dev_ev.power_stage_supply_ov;
		next_pwr_status[`CSF_PWR_POWER_STAGE_SUPPLY_UV] = i_dev_ev.power_stage_supply_uv;
		next_pwr_status[`CSF_PWR_GATE_DRIVE_SUPPLY]    = i_dev_ev.gate_drive_supply;
		next_tc_status   = {i_dev_ev.clk_invalid, 2'b00, i_dev_ev.over_temp_shutdown, i_chan_ev.ch_over_temp_shutdown};
		next_warn_status = {2'b00, i_dev_ev.foldback, i_dev_ev.over_temp_warning, i_chan_ev.load_warn};
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_pwr_status      <= `CSF_BYTE_ZERO;
			o_temp_clk_status <= `CSF_BYTE_ZERO;
			o_warn_status     <= `CSF_BYTE_ZERO;
		end else begin
			o_pwr_status      <= next_pwr_status;
			o_temp_clk_status <= next_tc_status;
			o_warn_status     <= next_warn_status;
		end
	end

	// memory set terms; the memory reset values are all zero, the reset flag comes from lrst_flag
	always_comb begin
		mem_set          = '0;
		mem_set.pwr      = next_pwr_status;
		mem_set.oc_dc    = {i_chan_ev.dc_fault, i_chan_ev.over_current_shutdown};
		mem_set.temp_clk = next_tc_status;
		mem_set.load     = {i_chan_ev.load_warn, i_chan_ev.load_fault};
		mem_set.warn     = {i_chan_ev.clip, 1'b0, 1'b0, i_dev_ev.foldback, i_dev_ev.over_temp_warning};
		mem_rst_val      = '0;
	end

	// logic supply reset flag: set at reset, dropped by the first power memory read
	logic lrst_flag;
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			lrst_flag <= 1'b1;
		end else if (i_mem_rd[0]) begin
			lrst_flag <= 1'b0;
		end
	end

	logic [7:0] pwr_mem_raw;
	csf_mem_reg u_mem_pwr (
		.i_sys_clk (i_sys_clk),
		.i_rst     (i_rst),
		.i_set     (mem_set.pwr),
		.i_rst_val (mem_rst_val.pwr),
		.i_rd      (i_mem_rd[0]),
		.o_data    (pwr_mem_raw)
	);
	assign o_mem.pwr = {lrst_flag, pwr_mem_raw[6:0]};

	csf_mem_reg u_mem_ocdc (
		.i_sys_clk (i_sys_clk),
		.i_rst     (i_rst),
		.i_set     (mem_set.oc_dc),
		.i_rst_val (mem_rst_val.oc_dc),
		.i_rd      (i_mem_rd[1]),
		.o_data    (o_mem.oc_dc)
	);
	csf_mem_reg u_mem_tc (
		.i_sys_clk (i_sys_clk),
		.i_rst     (i_rst),
		.i_set     (mem_set.temp_clk),
		.i_rst_val (mem_rst_val.temp_clk),
		.i_rd      (i_mem_rd[2]),
		.o_data    (o_mem.temp_clk)
	);
	csf_mem_reg u_mem_load (
		.i_sys_clk (i_sys_clk),
		.i_rst     (i_rst),
		.i_set     (mem_set.load),
		.i_rst_val (mem_rst_val.load),
		.i_rd      (i_mem_rd[3]),
		.o_data    (o_mem.load)
	);
	csf_mem_reg u_mem_warn (
		.i_sys_clk (i_sys_clk),
		.i_rst     (i_rst),
		.i_set     (mem_set.warn),
		.i_rst_val (mem_rst_val.warn),
		.i_rd      (i_mem_rd[4]),
		.o_data    (o_mem.warn)
	);

	// alert event vector: live power, over_temp_shutdown, clock, otw, foldback, then latched memories
	logic any_lpsd;
	always_comb begin
		any_lpsd = 1'b0;
		for (int k = 0; k < `CSF_NCH; k++) begin
			any_lpsd = any_lpsd | (st[k] == CSF_LPSD);
		end
	end
	assign ev_vec = {any_lpsd, |o_mem.oc_dc, |o_mem.load, |o_mem.temp_clk,
		i_dev_ev.foldback, i_dev_ev.over_temp_warning, i_dev_ev.clk_invalid, i_dev_ev.over_temp_shutdown, pwr_any};

	// registered so the pins never glitch on a mask write
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_warn_n  <= 1'b1;
			o_fault_n <= 1'b1;
		end else begin
			o_warn_n  <= ~|(ev_vec & i_warn_mask);
			o_fault_n <= ~|(ev_vec & i_fault_mask);
		end
	end
endmodule : csf_fault_report

// ===== design/csf_mem_reg.sv
// clear-on-read event memory register, one byte
`timescale 1ns/10ps
`include "csf_map.svh"
module csf_mem_reg (
	// clock and reset
	input  wire logic       i_sys_clk,
	input  wire logic       i_rst,
	// event side
	input  wire logic [7:0] i_set,
	input  wire logic [7:0] i_rst_val,
	// host side
	input  wire logic       i_rd,
	output logic      [7:0] o_data
);
	logic [7:0] held;

	// set wins over the clear caused by a read in the same cycle
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			held <= `CSF_BYTE_ZERO;
		end else if (i_rd) begin
			held <= i_set;
		end else begin
			held <= held | i_set;
		end
	end

	// reset value is ORed into the output every cycle; the logic supply flag is added outside, not through it
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_data <= `CSF_BYTE_ZERO;
		end else begin
			o_data <= held | i_rst_val;
		end
	end
endmodule : csf_mem_reg

// ===== shared/csf_map.svh
// register field positions, state codes and reset values for the channel fault block
`ifndef CSF_MAP_SVH
`define CSF_MAP_SVH

`define CSF_NCH          4
`define CSF_CODE_DIAGNOSTIC_STATE    3'h0
`define CSF_CODE_HIZ     3'h1
`define CSF_CODE_MUTE    3'h2
`define CSF_CODE_PLAY    3'h3
`define CSF_CODE_SRSD    3'h4
`define CSF_CODE_LPSD    3'h5
`define CSF_PWR_VBAT_OV  0
`define CSF_PWR_VBAT_UV  1
`define CSF_PWR_POWER_STAGE_SUPPLY_OV  2
`define CSF_PWR_POWER_STAGE_SUPPLY_UV  3
`define CSF_PWR_GATE_DRIVE_SUPPLY     4
`define CSF_PWR_LRST     7
`define CSF_BYTE_ZERO    8'h00
`define CSF_NIB_ZERO     4'h0

`endif

// ===== shared/csf_pkg.sv
// types shared by the channel state and fault report block
package csf_pkg;

	typedef enum logic [2:0] {
		CSF_DIAGNOSTIC_STATE,
		CSF_HIZ,
		CSF_MUTE,
		CSF_PLAY,
		CSF_SRSD,
		CSF_LPSD
	} csf_state_t;

	// per channel fault causes, one bit per channel
	typedef struct packed {
		logic [3:0] ch_over_temp_shutdown;
		logic [3:0] over_current_shutdown;
		logic [3:0] dc_fault;
		logic [3:0] load_fault;
		logic [3:0] load_warn;
		logic [3:0] clip;
	} csf_chan_ev_t;

	// device wide causes
	typedef struct packed {
		logic       vbat_ov;
		logic       vbat_uv;
		logic       power_stage_supply_ov;
		logic       power_stage_supply_uv;
		logic       gate_drive_supply;
		logic       over_temp_shutdown;
		logic       clk_invalid;
		logic       over_temp_warning;
		logic       foldback;
	} csf_dev_ev_t;

	// host controls
	typedef struct packed {
		logic       run_diagnostic_state;
		logic       go_hiz;
		logic       go_mute;
		logic       go_play;
		logic       over_temp_shutdown_auto_rec;
		logic       fault_clear;
	} csf_ctrl_t;

	// memory register contents
	typedef struct packed {
		logic [7:0] pwr;
		logic [7:0] oc_dc;
		logic [7:0] temp_clk;
		logic [7:0] load;
		logic [7:0] warn;
	} csf_mem_t;

endpackage : csf_pkg

// ===== verif/channel_state_fault_report_test.sv
// self-checking bench for the channel state and fault report block
`timescale 1ns/10ps
module channel_state_fault_report_test;
	import csf_pkg::*;
	logic         clk = 1'b0;
	logic         rst = 1'b1;
	csf_chan_ev_t ce = '0;
	csf_dev_ev_t  de = '0;
	csf_ctrl_t    ct = '0;
	logic [8:0]   wm = 9'h008;
	logic [8:0]   fm = 9'h001;
	logic [4:0]   rd;
	logic         fc;
	logic [3:0]   sw, osc;
	logic [7:0]   s12, s34, ps, ts, ws;
	csf_mem_t     mem;
	logic         wn, fn;
	logic [7:0]   obs [8];
	logic [10:0]  notes [$];
	logic [10:0]  n;
	int           fails = 0;
	int           checks = 0;
	int           seed = 81686;
	int           k;

	always #2 clk = ~clk;

	csf_host host (.i_sys_clk(clk), .o_mem_rd(rd), .o_fault_clear(fc));
	csf_fault_report uut (.i_sys_clk(clk), .i_rst(rst), .i_chan_ev(ce), .i_dev_ev(de),
		.i_ctrl({ct[5:1], fc}), .i_warn_mask(wm), .i_fault_mask(fm), .i_mem_rd(rd),
		.o_switching(sw), .o_osc_run(osc), .o_state_12(s12), .o_state_34(s34),
		.o_pwr_status(ps), .o_temp_clk_status(ts), .o_warn_status(ws), .o_mem(mem),
		.o_warn_n(wn), .o_fault_n(fn));

	always_comb obs = '{s12, s34, ps, ts, mem.oc_dc, mem.pwr, {sw, osc}, {ws[5:0], wn, fn}};

	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		checks++;
		if (seen !== want) begin
			fails++;
			$display("[FAIL] %0t saw %h expected %h", $time, seen, want);
		end
	endtask : check

	task automatic note(input logic [2:0] sel, input logic [7:0] val);
		// one cycle per note, so inputs keep changing just after the rising edge
		notes.push_back({sel, val});
		@(posedge clk) #1;
	endtask : note

	task automatic step(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask : step

	task automatic complete_run();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : complete_run

	// watcher: each strobed result is matched against the oldest note
	always @(negedge clk) begin
		if (notes.size() > 0) begin
			n = notes.pop_front();
			check(obs[n[10:8]], n[7:0]);
		end
	end

	initial begin
		#4000;
		fails++;
		complete_run();
	end

	initial begin
		step(4);
		rst = 1'b0;
		note(3'h0, 8'h11);
		note(3'h1, 8'h11);
		note(3'h5, 8'h80);
		host.read(0);
		step(2);
		note(3'h5, 8'h00);
		$display("reset test done");
		// every mode request, lowest priority last so play is left standing
		for (int m = 0; m < 4; m++) begin
			ct = '0;
			ct[5 - m] = 1'b1;
			step(3);
			note(3'h0, {2{1'b0, m[2:0]}});
			note(3'h1, {2{1'b0, m[2:0]}});
			note(3'h6, {{4{m == 3}}, {4{m != 0}}});
		end
		$display("mode test done");
		ct = '0;
		ce.over_current_shutdown = 4'h1;
		step(1);
		ce.over_current_shutdown = 4'h0;
		step(2);
		note(3'h0, 8'h35);
		note(3'h3, 8'h00);
		note(3'h4, 8'h01);
		host.clear();
		step(2);
		note(3'h0, 8'h31);
		host.read(1);
		step(2);
		note(3'h4, 8'h00);
		note(3'h0, 8'h31);
		$display("latched shutdown test done");
		ct.go_play = 1'b1;
		step(3);
		ct = '0;
		k = $unsigned($random(seed)) % 5;
		de[8 - k] = 1'b1;
		step(3);
		note(3'h0, 8'h44);
		note(3'h1, 8'h44);
		note(3'h2, 8'h01 << k);
		note(3'h5, 8'h01 << k);
		note(3'h7, 8'h02);
		de = '0;
		step(3);
		note(3'h0, 8'h33);
		$display("power fault test done");
		// global over-temp, latching first, then self-recovering
		for (int a = 0; a < 2; a++) begin
			ct.over_temp_shutdown_auto_rec = a[0];
			de.over_temp_shutdown = 1'b1;
			step(3);
			note(3'h1, (a == 1) ? 8'h44 : 8'h55);
			note(3'h3, 8'h10);
			de.over_temp_shutdown = 1'b0;
			host.clear();
			ct.go_play = 1'b1;
			step(3);
			note(3'h1, 8'h33);
			ct.go_play = 1'b0;
		end
		ce.load_fault = 4'h2;
		step(1);
		ce.load_fault = 4'h0;
		step(2);
		note(3'h0, 8'h53);
		de.over_temp_warning = 1'b1;
		step(2);
		note(3'h7, 8'h41);
		$display("over-temp test done");
		complete_run();
	end
endmodule : channel_state_fault_report_test

// ===== verif/csf_fault_report_props.sv
// concurrent checks on the ports of the channel state and fault report block
`timescale 1ns/10ps
module csf_fault_report_props
	import csf_pkg::*;
(
	// clock and reset
	input wire logic              i_sys_clk,
	input wire logic              i_rst,
	// watched inputs
	input csf_pkg::csf_chan_ev_t  i_chan_ev,
	input csf_pkg::csf_dev_ev_t   i_dev_ev,
	input csf_pkg::csf_ctrl_t     i_ctrl,
	input wire logic [8:0]        i_warn_mask,
	input wire logic [8:0]        i_fault_mask,
	input wire logic [4:0]        i_mem_rd,
	// watched outputs
	input wire logic [3:0]        o_switching,
	input wire logic [3:0]        o_osc_run,
	input wire logic [7:0]        o_state_12,
	input wire logic [7:0]        o_pwr_status,
	input csf_pkg::csf_mem_t      o_mem,
	input wire logic              o_warn_n,
	input wire logic              o_fault_n
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);
	// over-current seen with no read strobe while it travels into memory
	sequence s_oc_set;
		i_chan_ev.over_current_shutdown[0] && !i_mem_rd[1] ##1 !i_mem_rd[1];
	endsequence
	// latched code with the clear bit low on both sides, so no clear can land
	sequence s_quiet_latch;
		o_state_12[2:0] == 3'h5 && !$past(i_ctrl.fault_clear) && !i_ctrl.fault_clear
			##1 !i_ctrl.fault_clear;
	endsequence
	a_play_drives: assert property ($rose(o_switching[0]) |=> o_state_12[2:0] == 3'h3)
		else $error("switching outside play");
	a_diagnostic_state_osc: assert property (!o_osc_run[0] |=> o_state_12[2:0] == 3'h0)
		else $error("oscillator stopped outside diagnostic_state");
	a_pwr_live: assert property (!$past(i_rst) |-> o_pwr_status[4:0] == $past({i_dev_ev.gate_drive_supply,
		i_dev_ev.power_stage_supply_uv, i_dev_ev.power_stage_supply_ov, i_dev_ev.vbat_uv, i_dev_ev.vbat_ov}))
		else $error("power status not live");
	a_oc_memory: assert property (s_oc_set |=> o_mem.oc_dc[0])
		else $error("over-current not stored");
	a_oc_latches: assert property (o_switching[0] && i_chan_ev.over_current_shutdown[0]
		|=> !o_switching[0] ##1 o_state_12[2:0] == 3'h5)
		else $error("over-current did not latch");
	a_clear_hiz: assert property ($rose(i_ctrl.fault_clear) && o_state_12[2:0] == 3'h5
		|-> ##2 o_state_12[2:0] == 3'h1)
		else $error("clear did not give hi-z");
	a_latch_holds: assert property (s_quiet_latch |=> o_state_12[2:0] == 3'h5)
		else $error("latched shutdown left without clear");
	a_fault_alert: assert property ((i_fault_mask == 9'h001 && |i_dev_ev[8:4])[*3] |-> !o_fault_n)
		else $error("fault alert missing");
	a_warn_alert: assert property ((i_warn_mask == 9'h008 && i_dev_ev.over_temp_warning)[*3] |-> !o_warn_n)
		else $error("warning alert missing");
	a_read_clears: assert property (i_mem_rd[1] && i_chan_ev.over_current_shutdown == 4'h0
		&& i_chan_ev.dc_fault == 4'h0 |-> ##2 o_mem.oc_dc == 8'h00)
		else $error("read did not clear memory");
	a_reset_flag: assert property ($fell(i_rst) |-> o_mem.pwr[7] && o_state_12 == 8'h11)
		else $error("reset defaults wrong");
endmodule : csf_fault_report_props

bind csf_fault_report csf_fault_report_props u_props (.*);

// ===== verif/csf_host.sv
// host controller model: memory read strobes and fault clear pulses
`timescale 1ns/10ps
module csf_host (
	// clock
	input  wire logic       i_sys_clk,
	// host requests
	output logic      [4:0] o_mem_rd,
	output logic            o_fault_clear
);
	initial begin
		o_mem_rd = 5'h00;
		o_fault_clear = 1'b0;
	end
	// one strobe per read, since each read empties the byte
	task automatic read(input int idx);
		@(posedge i_sys_clk) #1 o_mem_rd = 5'h01 << idx;
		@(posedge i_sys_clk) #1 o_mem_rd = 5'h00;
	endtask : read
	// a fresh pulse for every clear, a held bit would clear only once
	task automatic clear();
		@(posedge i_sys_clk) #1 o_fault_clear = 1'b1;
		@(posedge i_sys_clk) #1 o_fault_clear = 1'b0;
	endtask : clear
endmodule : csf_host
